// >>> rtl/wdm_clk_mon.sv
`timescale 1ns/1ns
`default_nettype none
`include "wdm_regs.svh"

module wdm_clk_mon #(
   parameter int LIMIT = `WDM_CM_LIMIT
) (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic resetn_i,
   // Instruction cycle strobe
   input  wire logic tick_i,
   // Slow clock flag
   output var  logic err_o
);

   localparam int CW = $clog2(LIMIT + 2);

   logic [CW-1:0] gap;
   logic [CW-1:0] next_gap;
   logic          next_err;

   if (LIMIT < 2) begin : g_chk
      $error("wdm_clk_mon: LIMIT too small");
   end

   // ----------------------------------------------------------------
   // Gap between instruction cycles, saturating past the limit
   // ----------------------------------------------------------------
   always_comb
   begin
      next_gap = gap;
      next_err = err_o;
      if (tick_i)
      begin
         next_gap = '0;
         next_err = 1'b0;
      end
      else if (gap != CW'(LIMIT + 1))
      begin
         next_gap = gap + 1'b1;
      end
      // Only a gap longer than one 5 kHz period is flagged
      if (!tick_i && gap >= CW'(LIMIT))
      begin
         next_err = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         gap   <= '0;
         err_o <= 1'b0;
      end
      else
      begin
         gap   <= next_gap;
         err_o <= next_err;
      end
   end

endmodule : wdm_clk_mon

`default_nettype wire

// >>> rtl/wdm_pkg.sv
// ----------------------------------------------------------------
// Types
// ----------------------------------------------------------------
package wdm_pkg;

   typedef enum logic [1:0] {
      st_idle,
      st_drive,
      st_hold,
      st_wait
   } wdm_state_t;

endpackage : wdm_pkg

// >>> rtl/wdm_regs.svh
`ifndef WDM_REGS_SVH
`define WDM_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define WDM_SVC_OFS     12'h000
`define WDM_STAT_OFS    12'h004

// ----------------------------------------------------------------
// Service register fields, reset values and option bit
// ----------------------------------------------------------------
`define WDM_SEL_MSB     7
`define WDM_SEL_LSB     6
`define WDM_KEY_MSB     5
`define WDM_KEY_LSB     1
`define WDM_CM_BIT      0
`define WDM_KEY         5'h0c
`define WDM_SEL_RST     2'h3
`define WDM_CM_RST      1'b1
`define WDM_OPT_BIT     2

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define WDM_ST_BUSY     0
`define WDM_ST_CFG      1
`define WDM_ST_EN       2
`define WDM_ST_CMERR    3
`define WDM_ST_LOWOFF   4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WDM_LOWER       17'h00800
`define WDM_UPPER_BASE  17'h02000
`define WDM_CLK_HZ      20000000
`define WDM_LS_HZ       32768
`define WDM_CM_MIN_HZ   5000
`define WDM_LS_DIV      (`WDM_CLK_HZ / `WDM_LS_HZ)
`define WDM_CM_LIMIT    (`WDM_CLK_HZ / `WDM_CM_MIN_HZ)
`define WDM_HOLD        16

`endif

// >>> rtl/wdm_top.sv
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "wdm_regs.svh"

//Operation
//- Option bit 2 low enables watchdog
//- Service byte: window, key, monitor select
//- Key field must equal 01100
//- Lower limit fixed at 2048 window ticks
//- Window select gives 8k to 64k
//- Time counted in instruction cycles, or low-speed clock ticks in low-speed mode
//- Bit 0 enables the clock monitor
//- No monitor error at 5 kHz or above
//- Both detectors inactive during reset
//- Reset arms 64k window, monitor on
//- Slow or dead clock flagged after reset
//- First keyed write fixes configuration forever
//- Later writes must match all bits
//- Service before lower limit is error
//- Boot entry suppresses lower, services now
//- Boot exit services watchdog once more
//- Active-low output, weak pull-up idle
//- Hold low 16 cycles past threshold
//- Service ignored while output driven
//- Key field reads back as zero
//- Halt and idle freeze watchdog only
module wdm_top
   import wdm_pkg::*;
#(
   parameter int LS_DIV = `WDM_LS_DIV,
   parameter int HOLD   = `WDM_HOLD
) (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        resetn_i,
   // APB slave
   input  wire logic [11:0] paddr_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] pwdata_i,
   output var  logic [31:0] prdata_o,
   output var  logic        pready_o,
   output var  logic        pslverr_o,
   // Core status
   input  wire logic [7:0]  option_i,
   input  wire logic        instr_tick_i,
   input  wire logic        low_speed_i,
   input  wire logic        halt_i,
   input  wire logic        idle_i,
   input  wire logic        boot_enter_i,
   input  wire logic        boot_exit_i,
   // Fault pin, open drain
   input  wire logic        watchdog_fault_out_i,
   output var  logic        watchdog_fault_out_o,
   output var  logic        watchdog_fault_out_oe_n_o
);

   if (LS_DIV < 2 || LS_DIV > 1023 || HOLD < 2 || HOLD > 31)
   begin : g_chk
      $error("wdm_top: LS_DIV or HOLD out of range");
   end

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic logic key_ok(input logic [7:0] v);
      return v[`WDM_KEY_MSB:`WDM_KEY_LSB] == `WDM_KEY;
   endfunction : key_ok

   function automatic logic [16:0] upper_of(input logic [1:0] s);
      return `WDM_UPPER_BASE << s;
   endfunction : upper_of

   logic [9:0]  ls_cnt;
   logic [9:0]  next_ls_cnt;
   logic        ls_tick;
   logic        next_ls_tick;
   logic        pin_s1;
   logic        pin_s2;
   logic        opt_done;
   logic        next_opt_done;
   logic        wd_en;
   logic        next_wd_en;
   logic [16:0] wcnt;
   logic [16:0] next_wcnt;
   logic        configured;
   logic        next_configured;
   logic [1:0]  sel;
   logic [1:0]  next_sel;
   logic        cm_en;
   logic        next_cm_en;
   logic        lower_off;
   logic        next_lower_off;
   logic        pm_q;
   logic        next_pm_q;
   wdm_state_t  st;
   wdm_state_t  next_st;
   logic [4:0]  hold_cnt;
   logic [4:0]  next_hold_cnt;
   logic        next_oe_n;
   logic        next_pready;
   logic        next_pslverr;
   logic [31:0] next_prdata;
   logic        cm_err;
   logic        tick;
   logic        pm;
   logic        busy;
   logic        svc_wr;
   logic [7:0]  svc_byte;
   logic        err_svc;
   logic        err_up;
   logic        cm_fault;
   logic        restart_win;

   assign pm       = halt_i | idle_i;
   assign busy     = st != st_idle;
   assign svc_byte = pwdata_i[7:0];
   assign svc_wr   = psel_i & penable_i & pwrite_i & ~pready_o
                     & (paddr_i == `WDM_SVC_OFS);
   assign tick     = low_speed_i ? ls_tick : instr_tick_i;
   assign cm_fault = cm_en & cm_err;
   assign restart_win = (st == st_wait) & pin_s2;

   // ----------------------------------------------------------------
   // Clock monitor
   // ----------------------------------------------------------------
   wdm_clk_mon #(
      .LIMIT (`WDM_CM_LIMIT)
   ) u_clk_mon (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .tick_i    (instr_tick_i),
      .err_o     (cm_err)
   );

   // ----------------------------------------------------------------
   // Low-speed clock divider, option capture, pin synchroniser
   // ----------------------------------------------------------------
   always_comb
   begin
      next_ls_cnt   = ls_cnt + 10'h001;
      next_ls_tick  = 1'b0;
      if (ls_cnt == 10'(LS_DIV - 1))
      begin
         next_ls_cnt  = 10'h000;
         next_ls_tick = 1'b1;
      end
      next_opt_done = 1'b1;
      next_wd_en    = wd_en;
      if (!opt_done)
      begin
         next_wd_en = ~option_i[`WDM_OPT_BIT];
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ls_cnt   <= 10'h000;
         ls_tick  <= 1'b0;
         opt_done <= 1'b0;
         wd_en    <= 1'b0;
         pin_s1   <= 1'b1;
         pin_s2   <= 1'b1;
      end
      else
      begin
         ls_cnt   <= next_ls_cnt;
         ls_tick  <= next_ls_tick;
         opt_done <= next_opt_done;
         wd_en    <= next_wd_en;
         pin_s1   <= watchdog_fault_out_i;
         pin_s2   <= pin_s1;
      end
   end

   // ----------------------------------------------------------------
   // Service window and configuration
   // ----------------------------------------------------------------
   assign err_up = tick & ~busy & ~pm & wd_en
                   & (wcnt == upper_of(sel) - 17'h00001);

   always_comb
   begin
      next_wcnt       = wcnt;
      next_configured = configured;
      next_sel        = sel;
      next_cm_en      = cm_en;
      next_lower_off  = lower_off;
      next_pm_q       = pm;
      err_svc         = 1'b0;
      if (restart_win || !wd_en)
      begin
         next_wcnt = 17'h00000;
      end
      else if (boot_enter_i || boot_exit_i)
      begin
         next_wcnt      = 17'h00000;
         next_lower_off = 1'b1;
      end
      else if (pm)
      begin
         next_wcnt = wcnt;
      end
      else if (pm_q)
      begin
         next_wcnt      = 17'h00000;
         next_lower_off = 1'b0;
      end
      else if (svc_wr && !busy)
      begin
         if (!configured)
         begin
            if (key_ok(svc_byte))
            begin
               next_configured = 1'b1;
               next_sel   = svc_byte[`WDM_SEL_MSB:`WDM_SEL_LSB];
               next_cm_en = svc_byte[`WDM_CM_BIT];
               next_wcnt      = 17'h00000;
               next_lower_off = 1'b0;
            end
            else
            begin
               err_svc = 1'b1;
            end
         end
         else if (svc_byte != {sel, `WDM_KEY, cm_en})
         begin
            err_svc = 1'b1;
         end
         else if (wcnt < `WDM_LOWER && !lower_off)
         begin
            err_svc = 1'b1;
         end
         else
         begin
            next_wcnt      = 17'h00000;
            next_lower_off = 1'b0;
         end
      end
      else if (tick && !busy)
      begin
         next_wcnt = wcnt + 17'h00001;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wcnt       <= 17'h00000;
         configured <= 1'b0;
         sel        <= `WDM_SEL_RST;
         cm_en      <= `WDM_CM_RST;
         lower_off  <= 1'b1;
         pm_q       <= 1'b0;
      end
      else
      begin
         wcnt       <= next_wcnt;
         configured <= next_configured;
         sel        <= next_sel;
         cm_en      <= next_cm_en;
         lower_off  <= next_lower_off;
         pm_q       <= next_pm_q;
      end
   end

   // ----------------------------------------------------------------
   // Fault pin sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      next_st       = st;
      next_hold_cnt = hold_cnt;
      unique case (st)
         st_idle:
            if (wd_en && (err_svc || err_up || cm_fault))
            begin
               next_st = st_drive;
            end
         st_drive:
            if (!pin_s2)
            begin
               next_st       = st_hold;
               next_hold_cnt = 5'h00;
            end
         st_hold:
            if (cm_fault)
            begin
               next_hold_cnt = 5'h00;
            end
            else if (hold_cnt == 5'(HOLD - 1))
            begin
               next_st = st_wait;
            end
            else
            begin
               next_hold_cnt = hold_cnt + 5'h01;
            end
         st_wait:
            if (pin_s2)
            begin
               next_st = st_idle;
            end
      endcase
      next_oe_n = ~(next_st == st_drive || next_st == st_hold);
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         st                        <= st_idle;
         hold_cnt                  <= 5'h00;
         watchdog_fault_out_oe_n_o <= 1'b1;
         watchdog_fault_out_o      <= 1'b0;
      end
      else
      begin
         st                        <= next_st;
         hold_cnt                  <= next_hold_cnt;
         watchdog_fault_out_oe_n_o <= next_oe_n;
         watchdog_fault_out_o      <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // APB slave, one wait state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_pready  = psel_i & penable_i & ~pready_o;
      next_pslverr = 1'b0;
      next_prdata  = 32'h00000000;
      if (next_pready)
      begin
         unique case (paddr_i)
            `WDM_SVC_OFS:
               if (!pwrite_i)
               begin
                  next_prdata[7:6] = sel;
                  next_prdata[0]   = cm_en;
               end
            `WDM_STAT_OFS:
               if (!pwrite_i)
               begin
                  next_prdata[`WDM_ST_BUSY]   = busy;
                  next_prdata[`WDM_ST_CFG]    = configured;
                  next_prdata[`WDM_ST_EN]     = wd_en;
                  next_prdata[`WDM_ST_CMERR]  = cm_fault;
                  next_prdata[`WDM_ST_LOWOFF] = lower_off;
               end
            default:
               next_pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
      end
      else
      begin
         pready_o  <= next_pready;
         pslverr_o <= next_pslverr;
         prdata_o  <= next_prdata;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_key_reject :
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      svc_wr && wd_en && st == st_idle && !configured
      && !key_ok(svc_byte) |=> st == st_drive ##1 !configured)
   else $error("bad key not flagged");

   a_reset_window :
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !configured |-> sel == 2'h3 && cm_en)
   else $error("reset window wrong");

   a_config_lock :
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      configured && $past(configured) |-> $stable(sel) && $stable(cm_en))
   else $error("config changed after lock");

   a_upper_expire :
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      st == st_idle && wd_en && tick && !pm && sel == 2'h0
      && wcnt == 17'h01fff |=> st == st_drive ##1 !watchdog_fault_out_oe_n_o)
   else $error("8k limit not enforced");

   a_early_svc :
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      svc_wr && wd_en && st == st_idle && configured && !lower_off && !pm
      && !pm_q && !boot_enter_i && !boot_exit_i
      && wcnt < 17'h00800 |=> st == st_drive)
   else $error("early service not flagged");

   a_ignore_busy :
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      svc_wr && busy && !boot_enter_i && !boot_exit_i && !restart_win
      |=> wcnt == $past(wcnt) && configured == $past(configured))
   else $error("service taken while driving");

   a_key_hidden :
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      pready_o && !pwrite_i && paddr_i == 12'h000 |-> prdata_o[5:1] == 5'h00)
   else $error("key visible on read");

   a_halt_freeze :
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      pm && $past(pm) && wd_en && !boot_enter_i && !boot_exit_i && !restart_win
      |=> wcnt == $past(wcnt))
   else $error("window ran in power save");

   // Cycles with the pin held low and no clock fault pending
   logic [5:0]  chk_quiet;
   logic [5:0]  next_chk_quiet;

   always_comb
   begin
      next_chk_quiet = chk_quiet;
      if (watchdog_fault_out_oe_n_o || pin_s2 || cm_fault)
      begin
         next_chk_quiet = 6'h00;
      end
      else if (chk_quiet != 6'h3f)
      begin
         next_chk_quiet = chk_quiet + 6'h01;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         chk_quiet <= 6'h00;
      end
      else
      begin
         chk_quiet <= next_chk_quiet;
      end
   end

   a_pin_release :
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !watchdog_fault_out_oe_n_o |-> chk_quiet <= 6'(HOLD))
   else $error("pin not released after hold");

   a_boot_service :
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      boot_enter_i && !restart_win |=> wcnt == 17'h00000 && lower_off)
   else $error("boot entry did not service");

   a_cm_flag :
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      st == st_idle && wd_en && cm_en && cm_err |=> st == st_drive)
   else $error("clock error not flagged");

endmodule : wdm_top

`default_nettype wire

// >>> tb/wdm_pin_model.sv
`timescale 1ns/1ns
`default_nettype none

module wdm_pin_model #(
   parameter int SLOW = 3
) (
   // Clock
   input  wire logic clk_sys_i,
   // Fault driver of the device
   input  wire logic drv_i,
   input  wire logic oe_n_i,
   // Reset line of the external circuit
   output var  logic pin_o
);
   int low_cnt = 0;

   // ----------------------------------------------------------------
   // Pull-up line, load slows the falling edge by SLOW clocks
   // ----------------------------------------------------------------
   always @(posedge clk_sys_i)
   begin
      if (oe_n_i || drv_i)
         low_cnt <= 0;
      else if (low_cnt < SLOW)
         low_cnt <= low_cnt + 1;
   end

   assign pin_o = (oe_n_i || drv_i || low_cnt < SLOW);

endmodule : wdm_pin_model

`default_nettype wire

// >>> tb/wdm_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module wdm_top_tb_top;
   import wdm_pkg::*;
   localparam int HOLD = 16;
   localparam int DIV  = 4;
   localparam int SLOW = 3;
   logic        clk_sys_i = 1'b0;
   logic        resetn_i  = 1'b0;
   logic [11:0] paddr     = 12'h000;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [31:0] pwdata    = 32'h0;
   logic [7:0]  option    = 8'h00;
   logic        tick      = 1'b0;
   logic        low_speed = 1'b0;
   logic        halt      = 1'b0;
   logic        idle      = 1'b0;
   logic        boot_in   = 1'b0;
   logic        boot_out  = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pin;
   logic        drv;
   logic        oe_n;
   int          err_count = 0;
   int          compares  = 0;
   longint      cyc       = 0;
   int          seed      = 32'hd5cf99ac;
   int          idx;
   logic [1:0]  m_sel;
   logic        m_cm;
   logic        m_cfg;
   logic        m_supp;
   longint      m_last;
   logic [31:0] rd;
   logic        er;
   logic        s;

   always #25 clk_sys_i = ~clk_sys_i;

   wdm_top #(.LS_DIV(DIV), .HOLD(HOLD)) dut (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .paddr_i(paddr),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .option_i(option), .instr_tick_i(tick),
      .low_speed_i(low_speed), .halt_i(halt), .idle_i(idle),
      .boot_enter_i(boot_in), .boot_exit_i(boot_out),
      .watchdog_fault_out_i(pin), .watchdog_fault_out_o(drv),
      .watchdog_fault_out_oe_n_o(oe_n));

   wdm_pin_model #(.SLOW(SLOW)) far (
      .clk_sys_i(clk_sys_i), .drv_i(drv), .oe_n_i(oe_n), .pin_o(pin));

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task close_out;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out

   always @(posedge clk_sys_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         err_count++;
         close_out();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys_i);
         n++;
      end
      while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1)
         err_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task run(input int n, output logic seen);
      seen = 1'b0;
      repeat (n)
      begin
         @(negedge clk_sys_i);
         if (oe_n === 1'b0)
            seen = 1'b1;
      end
   endtask : run

   task rel;
      int n;
      n = 0;
      while ((oe_n !== 1'b1 || pin !== 1'b1) && n < 300)
      begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n >= 300)
         err_count++;
      repeat (4) @(negedge clk_sys_i);
      m_last = cyc;
   endtask : rel

   task watch(input int win, output logic seen);
      int n;
      seen = 1'b0;
      n = 0;
      while (!seen && n < win)
      begin
         @(negedge clk_sys_i);
         n++;
         seen = (oe_n === 1'b0);
      end
      if (seen)
      begin
         n = 0;
         while (oe_n === 1'b0 && n < 100)
         begin
            @(negedge clk_sys_i);
            n++;
         end
         chk(32'(n >= HOLD + 2 && n <= 2 * HOLD + SLOW + 4), 32'h1);
         rel();
      end
   endtask : watch

   // Reference model of the service checks, then the write itself
   task svc(input logic [7:0] d, input int gap);
      logic   ex;
      logic   sn;
      longint el;
      run(gap, sn);
      chk(32'(sn), 32'h0);
      el = (cyc - m_last) / (low_speed ? DIV : 1);
      if (m_cfg)
         ex = (d != {m_sel, 5'h0c, m_cm}) || (!m_supp && el < 2048);
      else
         ex = (d[5:1] != 5'h0c);
      apb(12'h000, 1'b1, {24'h0, d});
      if (!ex)
      begin
         if (!m_cfg)
         begin
            m_sel = d[7:6];
            m_cm = d[0];
         end
         m_cfg = 1'b1;
         m_supp = 1'b0;
         m_last = cyc;
      end
      watch(8, sn);
      chk(32'(sn), 32'(ex));
   endtask : svc

   task rst(input logic [7:0] opt);
      resetn_i <= 1'b0;
      option <= opt;
      repeat (4) @(posedge clk_sys_i);
      chk(32'(oe_n), 32'h1);
      resetn_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      {m_sel, m_cm, m_cfg, m_supp} = 5'b11101;
      m_last = cyc;
   endtask : rst

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      rst(8'h00);
      apb(12'h000, 1'b0, 32'h0);
      chk(rd, 32'hc1);
      apb(12'h004, 1'b0, 32'h0);
      chk(rd, 32'h14);
      apb(12'h008, 1'b1, 32'h0);
      chk(32'(er), 32'h1);
      run(3850, s);
      chk(32'(s), 32'h0);
      run(300, s);
      chk(32'(s), 32'h1);
      apb(12'h000, 1'b1, 32'h18);
      apb(12'h004, 1'b0, 32'h0);
      chk(rd, 32'h1d);
      chk(32'({drv, oe_n}), 32'h0);
      tick <= 1'b1;
      rel();
      rst(8'h00);
      svc(8'h1a, 2100);
      svc(8'h18, 2100);
      apb(12'h000, 1'b0, 32'h0);
      chk(rd, 32'h00);
      svc(8'h58, 2100);
      repeat (3)
      begin
         idx = $random(seed) & 32'h7;
         svc(8'h18 ^ (8'h01 << idx[2:0]), 2100);
      end
      svc(8'h18, 2100);
      svc(8'h18, 5);
      svc(8'h18, 2100);
      svc(8'h18, 2100);
      run(8192 - 40, s);
      chk(32'(s), 32'h0);
      watch(80, s);
      chk(32'(s), 32'h1);
      for (int i = 0; i < 2; i++)
      begin
         svc(8'h18, 2100);
         @(posedge clk_sys_i);
         boot_in <= (i == 0);
         boot_out <= (i == 1);
         @(posedge clk_sys_i);
         boot_in <= 1'b0;
         boot_out <= 1'b0;
         m_supp = 1'b1;
         m_last = cyc;
         svc(8'h18, 5);
      end
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk_sys_i);
         halt <= (i == 0);
         idle <= (i == 1);
         run(9000, s);
         chk(32'(s), 32'h0);
         @(posedge clk_sys_i);
         halt <= 1'b0;
         idle <= 1'b0;
         m_supp = 1'b0;
         m_last = cyc;
         svc(8'h18, 5);
      end
      svc(8'h18, 2100);
      low_speed <= 1'b1;
      svc(8'h18, 2100);
      low_speed <= 1'b0;
      rst(8'h04);
      tick <= 1'b0;
      apb(12'h004, 1'b0, 32'h0);
      chk(rd & 32'h4, 32'h0);
      run(4500, s);
      chk(32'(s), 32'h0);
      close_out();
   end

endmodule : wdm_top_tb_top

`default_nettype wire
